// file: hw/lics_pkg.sv
// Package with the timing and encoding constants of the charge sequencer.
package lics_pkg;
	// Clock rate and default maximum charge time.
	localparam int unsigned CLK_HZ              = 20_000_000;
	localparam int unsigned MAX_CHARGE_TIME_S   = 3600;
	localparam longint      MAX_CHARGE_CYCLES   = longint'(MAX_CHARGE_TIME_S) * longint'(CLK_HZ);
	// Fixed divisions of the maximum charge time, and the timer width.
	localparam int unsigned PRECHARGE_DIV       = 8;
	localparam int unsigned DEGLITCH_DIV        = 220;
	localparam int unsigned TIMER_W             = 40;
	// Synchroniser depth for comparator inputs.
	localparam int unsigned SYNC_STAGES         = 3;
	// Status line encodings: {first, second}.
	localparam logic [1:0]  STATUS_CHARGING     = 2'h2;
	localparam logic [1:0]  STATUS_DONE         = 2'h1;
	localparam logic [1:0]  STATUS_STANDBY      = 2'h0;
	localparam logic [1:0]  STATUS_FAULT        = 2'h3;

	typedef enum logic [2:0] {
		LICS_IDLE,
		LICS_PRECHARGE,
		LICS_FAST,
		LICS_REGULATE,
		LICS_END_OF_CHARGE,
		LICS_FAULT
	} lics_state_t;
endpackage

// file: hw/lics_sequencer.sv
// Charge-process sequencer of a single-cell lithium charger.
`timescale 1ns/10ps
// What this block does
// - Floating threshold pin selects default threshold.
// - Battery above threshold skips pre-charge.
// - Pre-charge limit eighth of max; expiry faults.
// - Reaching threshold enters fast charge.
// - Max timer starts at fast; expiry faults.
// - Near regulation level enters voltage regulation.
// - Below recharge threshold restarts from end.
// - Done shown after deglitch of max/220.
// - Pin above select level terminates at threshold.
// - Pin below level continues, end shown fault.
// - Pin low in pre-charge uses default.
// - Falling timer-reset edge clears active timer.
// - Temperature outside window halts, then resumes.
// - Cold limit stops high, releases lower.
// - Hot limit stops low, releases higher.
// - Status lines encode charging, done, standby, fault.
// - Faults exit to recharge decision flow.
// - Supply below battery shows standby.
module lics_sequencer #(
	parameter longint MAX_CHARGE_CYCLES = lics_pkg::MAX_CHARGE_CYCLES
) (
	input  wire logic clk,
	input  wire logic rstn,
	input  wire logic ce,
	input  wire logic charge_enable,
	input  wire logic pin_floating,
	input  wire logic bat_above_programmed_threshold,
	input  wire logic bat_above_default_threshold,
	input  wire logic pin_above_select_level,
	input  wire logic pin_above_timer_reset_level,
	input  wire logic bat_near_regulation,
	input  wire logic current_below_end_threshold,
	input  wire logic bat_below_recharge_threshold,
	input  wire logic therm_above_cold_limit,
	input  wire logic therm_below_cold_release,
	input  wire logic therm_below_hot_limit,
	input  wire logic therm_above_hot_release,
	input  wire logic supply_below_battery,
	output logic      charge_on,
	output logic      precharge_current,
	output logic      status_line_first,
	output logic      status_line_second
);
	localparam int NIN = 13;
	// Positions of the comparator decisions in the synchroniser vector.
	localparam int IX_EN       = 12;
	localparam int IX_FLOAT    = 11;
	localparam int IX_PROG     = 10;
	localparam int IX_DEF      = 9;
	localparam int IX_SEL      = 8;
	localparam int IX_TRST     = 7;
	localparam int IX_NEAR     = 6;
	localparam int IX_CUR      = 5;
	localparam int IX_RCH      = 4;
	localparam int IX_COLD     = 3;
	localparam int IX_COLD_REL = 2;
	localparam int IX_HOT      = 1;
	localparam int IX_STANDBY  = 0;
	localparam logic [lics_pkg::TIMER_W-1:0] MAXC = lics_pkg::TIMER_W'(MAX_CHARGE_CYCLES);
	localparam logic [lics_pkg::TIMER_W-1:0] PREC =
		lics_pkg::TIMER_W'(MAX_CHARGE_CYCLES / lics_pkg::PRECHARGE_DIV);
	localparam logic [lics_pkg::TIMER_W-1:0] DEGC =
		lics_pkg::TIMER_W'(MAX_CHARGE_CYCLES / lics_pkg::DEGLITCH_DIV);

	// Three-stage synchronisers; a change is taken once stages two and three agree.
	logic [NIN-1:0] raw;
	logic [NIN-1:0] s1;
	logic [NIN-1:0] s2;
	logic [NIN-1:0] s3;
	logic [NIN-1:0] filt;
	logic [NIN-1:0] next_filt;
	logic           filt_pin_rst_d;
	logic           next_filt_pin_rst_d;

	assign raw = {charge_enable, pin_floating, bat_above_programmed_threshold, bat_above_default_threshold,
		pin_above_select_level, pin_above_timer_reset_level, bat_near_regulation,
		current_below_end_threshold, bat_below_recharge_threshold, therm_above_cold_limit,
		therm_below_cold_release, therm_below_hot_limit, supply_below_battery};

	always_comb begin
		next_filt = filt;
		for (int i = 0; i < NIN; i++) begin
			if (s2[i] == s3[i]) begin
				next_filt[i] = s3[i];
			end
		end
		next_filt_pin_rst_d = filt[IX_TRST];
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			s1 <= '0;
			s2 <= '0;
			s3 <= '0;
			filt <= '0;
			filt_pin_rst_d <= 1'b0;
		end else if (ce) begin
			s1 <= raw;
			s2 <= s1;
			s3 <= s2;
			filt <= next_filt;
			filt_pin_rst_d <= next_filt_pin_rst_d;
		end
	end

	// Hot release comparator gets its own synchroniser so the vector stays compact.
	logic [lics_pkg::SYNC_STAGES-1:0] hr_sync;
	logic                             hot_rel;
	logic                             next_hot_rel;

	always_comb begin
		next_hot_rel = hot_rel;
		if (hr_sync[lics_pkg::SYNC_STAGES-2] == hr_sync[lics_pkg::SYNC_STAGES-1]) begin
			next_hot_rel = hr_sync[lics_pkg::SYNC_STAGES-1];
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			hr_sync <= '0;
			hot_rel <= 1'b0;
		end else if (ce) begin
			hr_sync <= {hr_sync[lics_pkg::SYNC_STAGES-2:0], therm_above_hot_release};
			hot_rel <= next_hot_rel;
		end
	end

	logic en_s;
	logic floating_s;
	logic above_prog_s;
	logic above_def_s;
	logic sel_high_s;
	logic near_reg_s;
	logic cur_low_s;
	logic rch_s;
	logic cold_s;
	logic cold_rel_s;
	logic hot_s;
	logic standby_s;
	logic timer_reset_edge;
	logic above_pre;

	assign en_s         = filt[IX_EN];
	assign floating_s   = filt[IX_FLOAT];
	assign above_prog_s = filt[IX_PROG];
	assign above_def_s  = filt[IX_DEF];
	assign sel_high_s   = filt[IX_SEL];
	assign near_reg_s   = filt[IX_NEAR];
	assign cur_low_s    = filt[IX_CUR];
	assign rch_s        = filt[IX_RCH];
	assign cold_s       = filt[IX_COLD];
	assign cold_rel_s   = filt[IX_COLD_REL];
	assign hot_s        = filt[IX_HOT];
	assign standby_s    = filt[IX_STANDBY];
	assign timer_reset_edge = filt_pin_rst_d && !filt[IX_TRST];

	// Floating pin, or pin low during pre-charge, forces the default threshold.
	assign above_pre = (floating_s || !sel_high_s) ? above_def_s : above_prog_s;

	// Temperature fault with hysteresis on both limits.
	logic temp_fault;
	logic next_temp_fault;

	always_comb begin
		next_temp_fault = temp_fault;
		if (cold_s || hot_s) begin
			next_temp_fault = 1'b1;
		end else if (temp_fault && cold_rel_s && hot_rel) begin
			next_temp_fault = 1'b0;
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			temp_fault <= 1'b0;
		end else if (ce) begin
			temp_fault <= next_temp_fault;
		end
	end

	// Saturating increment shared by the safety timer and the deglitch counter.
	function automatic logic [lics_pkg::TIMER_W-1:0] sat_inc(
		input logic [lics_pkg::TIMER_W-1:0] value,
		input logic [lics_pkg::TIMER_W-1:0] limit
	);
		return (value >= limit) ? value : value + 1'b1;
	endfunction

	// Main sequencer with safety timer and end-of-charge deglitch counter.
	lics_pkg::lics_state_t           state;
	lics_pkg::lics_state_t           next_state;
	logic [lics_pkg::TIMER_W-1:0]   timer;
	logic [lics_pkg::TIMER_W-1:0]   next_timer;
	logic [lics_pkg::TIMER_W-1:0]   degl;
	logic [lics_pkg::TIMER_W-1:0]   next_degl;
	logic                           end_seen;
	logic                           next_end_seen;
	logic                           degl_done;

	assign degl_done = (degl >= DEGC);

	always_comb begin
		next_state = state;
		next_timer = timer;
		next_degl = degl;
		next_end_seen = end_seen;
		next_timer = sat_inc(timer, '1);
		if (cur_low_s && (state == lics_pkg::LICS_REGULATE || state == lics_pkg::LICS_FAST)) begin
			next_degl = sat_inc(degl, DEGC);
		end else begin
			next_degl = '0;
		end
		if (timer_reset_edge) begin
			next_timer = '0;
		end
		unique case (state)
			lics_pkg::LICS_IDLE: begin
				next_timer = '0;
				next_end_seen = 1'b0;
				if (en_s && !temp_fault) begin
					next_state = above_pre ? lics_pkg::LICS_FAST : lics_pkg::LICS_PRECHARGE;
				end
			end
			lics_pkg::LICS_PRECHARGE: begin
				if (above_pre) begin
					next_state = lics_pkg::LICS_FAST;
					next_timer = '0;
				end else if (timer >= PREC) begin
					next_state = lics_pkg::LICS_FAULT;
				end
			end
			lics_pkg::LICS_FAST, lics_pkg::LICS_REGULATE: begin
				if (state == lics_pkg::LICS_FAST && near_reg_s) begin
					next_state = lics_pkg::LICS_REGULATE;
				end
				if (degl_done && sel_high_s) begin
					next_state = lics_pkg::LICS_END_OF_CHARGE;
				end else if (degl_done) begin
					next_end_seen = 1'b1;
				end
				if (timer >= MAXC) begin
					next_state = lics_pkg::LICS_FAULT;
				end
			end
			lics_pkg::LICS_END_OF_CHARGE: begin
				if (rch_s) begin
					next_state = lics_pkg::LICS_IDLE;
				end
			end
			lics_pkg::LICS_FAULT: begin
				if (rch_s) begin
					next_state = lics_pkg::LICS_IDLE;
				end
			end
		endcase
		if (!en_s) begin
			next_state = lics_pkg::LICS_IDLE;
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			state <= lics_pkg::LICS_IDLE;
			timer <= '0;
			degl <= '0;
			end_seen <= 1'b0;
		end else if (ce) begin
			state <= next_state;
			timer <= next_timer;
			degl <= next_degl;
			end_seen <= next_end_seen;
		end
	end

	// Registered outputs.
	logic       next_charge_on;
	logic       next_precharge_current;
	logic [1:0] next_status;

	always_comb begin
		next_charge_on = !temp_fault && (state == lics_pkg::LICS_PRECHARGE || state == lics_pkg::LICS_FAST
			|| state == lics_pkg::LICS_REGULATE);
		next_precharge_current = (state == lics_pkg::LICS_PRECHARGE);
		if (standby_s) begin
			next_status = lics_pkg::STATUS_STANDBY;
		end else if (temp_fault || state == lics_pkg::LICS_FAULT || end_seen) begin
			next_status = lics_pkg::STATUS_FAULT;
		end else if (state == lics_pkg::LICS_END_OF_CHARGE) begin
			next_status = lics_pkg::STATUS_DONE;
		end else if (state == lics_pkg::LICS_IDLE) begin
			next_status = lics_pkg::STATUS_STANDBY;
		end else begin
			next_status = lics_pkg::STATUS_CHARGING;
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			charge_on <= 1'b0;
			precharge_current <= 1'b0;
			status_line_first <= 1'b0;
			status_line_second <= 1'b0;
		end else if (ce) begin
			charge_on <= next_charge_on;
			precharge_current <= next_precharge_current;
			status_line_first <= next_status[1];
			status_line_second <= next_status[0];
		end
	end
endmodule

// file: bench/lics_pack.sv
// Behavioural battery pack, thermistor divider and front-end comparators.
`timescale 1ns/10ps
module lics_pack (
	input  wire logic [15:0] vbat,
	input  wire logic [15:0] therm_mv,
	input  wire logic [15:0] pin,
	input  wire logic [15:0] vin,
	input  wire logic [15:0] cur,
	output logic             bat_above_programmed_threshold,
	output logic             bat_above_default_threshold,
	output logic             pin_above_select_level,
	output logic             pin_above_timer_reset_level,
	output logic             bat_near_regulation,
	output logic             current_below_end_threshold,
	output logic             bat_below_recharge_threshold,
	output logic             therm_above_cold_limit,
	output logic             therm_below_cold_release,
	output logic             therm_below_hot_limit,
	output logic             therm_above_hot_release,
	output logic             supply_below_battery
);
	// Values are millivolts and milliamps; the resistor-set threshold sits at 3.0 V.
	assign bat_above_programmed_threshold = vbat > 16'h0BB8;
	assign bat_above_default_threshold = vbat > 16'h0AF0;
	assign pin_above_select_level = pin > 16'h0320;
	assign pin_above_timer_reset_level = pin > 16'h01F4;
	assign bat_near_regulation = vbat > 16'h1036;
	assign current_below_end_threshold = cur < 16'h0018;
	assign bat_below_recharge_threshold = vbat < 16'h0FD2;
	assign therm_above_cold_limit = therm_mv > 16'h0384;
	assign therm_below_cold_release = therm_mv < 16'h030C;
	assign therm_below_hot_limit = therm_mv < 16'h00E1;
	assign therm_above_hot_release = therm_mv > 16'h00F8;
	assign supply_below_battery = vin + 16'h0032 < vbat;
endmodule

// file: bench/lics_seq_sva.sv
// Port-level assertions of the charge sequencer.
`timescale 1ns/10ps
module lics_seq_sva #(
	parameter longint MAX_CHARGE_CYCLES = lics_pkg::MAX_CHARGE_CYCLES
) (
	input wire logic clk,
	input wire logic rstn,
	input wire logic charge_enable,
	input wire logic current_below_end_threshold,
	input wire logic therm_above_cold_limit,
	input wire logic therm_below_hot_limit,
	input wire logic supply_below_battery,
	input wire logic charge_on,
	input wire logic status_line_first,
	input wire logic status_line_second
);
	localparam longint DG = MAX_CHARGE_CYCLES / lics_pkg::DEGLITCH_DIV;
	logic [lics_pkg::TIMER_W-1:0] low_run;
	logic [lics_pkg::TIMER_W-1:0] next_low_run;
	wire  [1:0]  st = {status_line_first, status_line_second};
	default clocking @(posedge clk);
	endclocking
	default disable iff (!rstn);
	always_comb next_low_run = !current_below_end_threshold ? '0 : low_run + lics_pkg::TIMER_W'(~&low_run);
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn)
			low_run <= '0;
		else
			low_run <= next_low_run;
	end
	chk_done_deglitch: assert property ($rose(st == lics_pkg::STATUS_DONE) |-> low_run >= DG)
		else $error("done shown too early");
	chk_charging_code: assert property (st == lics_pkg::STATUS_CHARGING |-> charge_on)
		else $error("charging shown while not charging");
	chk_done_code: assert property (st == lics_pkg::STATUS_DONE |-> !charge_on)
		else $error("charging continues after done");
	chk_cold_halt: assert property (therm_above_cold_limit [*8] |=> !charge_on)
		else $error("charging while cold");
	chk_hot_halt: assert property (therm_below_hot_limit [*8] |=> !charge_on)
		else $error("charging while hot");
	chk_temp_shown: assert property ((therm_above_cold_limit || therm_below_hot_limit) [*8] |=> st != 2'h2)
		else $error("temperature fault shown as charging");
	chk_standby_code: assert property (supply_below_battery [*8] |=> st == lics_pkg::STATUS_STANDBY)
		else $error("standby not shown");
	chk_enable_sync: assert property ($rose(charge_on) |-> $past(charge_enable, 2) && $past(charge_enable, 4))
		else $error("charging started without settled enable");
endmodule
bind lics_sequencer lics_seq_sva #(.MAX_CHARGE_CYCLES(MAX_CHARGE_CYCLES)) u_lics_seq_sva (.*);

// file: bench/tb_li_ion_charge_sequencer.sv
// Self-checking testbench of the charge sequencer with a behavioural pack model.
`timescale 1ns/10ps
module tb_li_ion_charge_sequencer;
	localparam longint MAXC = 2200;
	logic clk = 1'b0, rstn = 1'b0, ce = 1'b1, charge_enable = 1'b0, pin_floating = 1'b1;
	logic [15:0] vbat = 16'h09C4, therm_mv = 16'h0258, pin = 16'h03E8, vin = 16'h1388, cur = 16'h00F0;
	wire bat_above_programmed_threshold, bat_above_default_threshold, pin_above_select_level;
	wire pin_above_timer_reset_level, bat_near_regulation, current_below_end_threshold;
	wire bat_below_recharge_threshold, therm_above_cold_limit, therm_below_cold_release;
	wire therm_below_hot_limit, therm_above_hot_release, supply_below_battery;
	wire charge_on, precharge_current, status_line_first, status_line_second;
	int n_mismatch = 0, n_tests = 0, cycles = 0, waited;
	logic [7:0] rnd = 8'h61;
	always #25 clk = ~clk;
	lics_pack u_lics_pack (.*);
	lics_sequencer #(.MAX_CHARGE_CYCLES(MAXC)) u_lics_sequencer (.*);
	function automatic logic [7:0] lfsr_next(input logic [7:0] x);
		return {x[6:0], x[7] ^ x[5] ^ x[4] ^ x[3]};
	endfunction
	task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
		n_tests++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("unexpected %s: expected %0h seen %0h", what, exp, seen);
		end
	endtask
	task automatic wait_st(input logic [1:0] want, input int lim);
		@(negedge clk);
		for (waited = 0; {status_line_first, status_line_second} !== want && waited < lim; waited++)
			@(negedge clk);
		chk("status", {status_line_first, status_line_second}, want);
	endtask
	task automatic restart(input logic [15:0] v, input logic fl, input logic [15:0] p);
		@(posedge clk);
		charge_enable <= 1'b0;
		pin_floating <= fl;
		pin <= p;
		vin <= 16'h1388;
		repeat (10) @(posedge clk);
		vbat <= v;
		charge_enable <= 1'b1;
	endtask
	task automatic close_out();
		$display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
		if (n_mismatch == 0 && n_tests > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	always @(posedge clk) begin
		cycles++;
		if (cycles == 20000) begin
			n_mismatch++;
			close_out();
		end
	end
	initial begin
		repeat (6) @(posedge clk);
		rstn <= 1'b1;
		charge_enable <= 1'b1;
		wait_st(lics_pkg::STATUS_CHARGING, 20);
		chk("precharge", precharge_current, 1'b1);
		@(posedge clk);
		vbat <= 16'h0B54;
		repeat (12) @(negedge clk);
		chk("precharge", precharge_current, 1'b0);
		$display("end precharge");
		@(posedge clk);
		vbat <= 16'h1054;
		cur <= 16'h000A;
		wait_st(lics_pkg::STATUS_DONE, 40);
		chk("deglitch", 16'(waited >= MAXC / lics_pkg::DEGLITCH_DIV), 16'h1);
		chk("charge_on", charge_on, 1'b0);
		@(posedge clk);
		vbat <= 16'h0FA0;
		cur <= 16'h00F0;
		wait_st(lics_pkg::STATUS_CHARGING, 30);
		chk("precharge", precharge_current, 1'b0);
		$display("end termination");
		@(posedge clk);
		pin <= 16'h02BC;
		vbat <= 16'h1054;
		cur <= 16'h000A;
		wait_st(lics_pkg::STATUS_FAULT, 40);
		chk("charge_on", charge_on, 1'b1);
		for (waited = 0; charge_on === 1'b1 && waited < 3000; waited++)
			@(negedge clk);
		chk("max_time", 16'(waited > MAXC - 100 && waited < MAXC), 16'h1);
		$display("end max time");
		@(posedge clk);
		pin <= 16'h03E8;
		vbat <= 16'h0FA0;
		cur <= 16'h00F0;
		wait_st(lics_pkg::STATUS_CHARGING, 30);
		@(posedge clk);
		ce <= 1'b0;
		charge_enable <= 1'b0;
		repeat (20) @(negedge clk);
		chk("frozen_status", {status_line_first, status_line_second}, lics_pkg::STATUS_CHARGING);
		chk("frozen_charge_on", charge_on, 1'b1);
		@(posedge clk);
		charge_enable <= 1'b1;
		ce <= 1'b1;
		for (int i = 0; i < 2; i++) begin
			rnd = lfsr_next(rnd);
			@(posedge clk);
			therm_mv <= (rnd[0] ^ i[0]) ? 16'h03E8 : 16'h00C8;
			wait_st(lics_pkg::STATUS_FAULT, 20);
			chk("charge_on", charge_on, 1'b0);
			@(posedge clk);
			therm_mv <= (rnd[0] ^ i[0]) ? 16'h0352 : 16'h00F0;
			repeat (20) @(negedge clk);
			chk("held", charge_on, 1'b0);
			@(posedge clk);
			therm_mv <= 16'h0258;
			wait_st(lics_pkg::STATUS_CHARGING, 20);
		end
		$display("end temperature");
		restart(16'h09C4, 1'b1, 16'h03E8);
		wait_st(lics_pkg::STATUS_CHARGING, 30);
		repeat (150) @(posedge clk);
		pin <= 16'h0190;
		repeat (3 + rnd[1:0]) @(posedge clk);
		pin <= 16'h03E8;
		wait_st(lics_pkg::STATUS_FAULT, 600);
		chk("timer_reset", 16'(waited > MAXC / lics_pkg::PRECHARGE_DIV - 20), 16'h1);
		chk("charge_on", charge_on, 1'b0);
		@(posedge clk);
		vin <= 16'h0900;
		wait_st(lics_pkg::STATUS_STANDBY, 20);
		$display("end pre-charge timer");
		for (int i = 0; i < 3; i++) begin
			restart(16'h0B54, i == 1, i == 2 ? 16'h02BC : 16'h03E8);
			wait_st(lics_pkg::STATUS_CHARGING, 30);
			chk("precharge", precharge_current, i == 0);
		end
		$display("end threshold select");
		close_out();
	end
endmodule
